// [verilog/lsvf_pkg.sv]
// lsvf_pkg: constants, types and field layout for the loop scale,
// output floor and switching frequency command words.
// assumes a word-wide command port from the host controller.
package lsvf_pkg;
    // command codes of the three words
    localparam logic [7:0] CMD_SCALE = 8'h29;
    localparam logic [7:0] CMD_FLOOR = 8'h2b;
    localparam logic [7:0] CMD_FREQ = 8'h33;
    // storage slots
    localparam logic [1:0] IDX_SCALE = 2'h0;
    localparam logic [1:0] IDX_FLOOR = 2'h1;
    localparam logic [1:0] IDX_FREQ = 2'h2;
    // linear word layout
    localparam int EXP_HI = 15;
    localparam int EXP_LO = 11;
    localparam int MAN_HI = 10;
    localparam int MAN_LO = 0;
    // divider scale exponent after reset (-7)
    localparam logic [4:0] SCALE_EXP_RST = 5'h19;
    // decoded values carry 16 fraction bits
    localparam int FRAC = 16;
    localparam logic signed [47:0] ONE_FIX = 48'sh0000_0001_0000;
    // divider scale band limits: 0.125, 0.25, 0.5
    localparam logic signed [47:0] SCALE_LIM0 = 48'sh0000_0000_2000;
    localparam logic signed [47:0] SCALE_LIM1 = 48'sh0000_0000_4000;
    localparam logic signed [47:0] SCALE_LIM2 = 48'sh0000_0000_8000;
    // highest frequency accepted, kHz (exclusive)
    localparam logic [10:0] FSW_LIMIT = 11'h672;
    // frequency band starts, kHz: 251 301 351 411 501 601 701 821 1001 1201 1401
    localparam int FSW_BANDS = 12;
    localparam logic [10:0] FSW_START [FSW_BANDS-1] = '{
        11'h0fb, 11'h12d, 11'h15f, 11'h19b, 11'h1f5, 11'h259,
        11'h2bd, 11'h335, 11'h3e9, 11'h4b1, 11'h579};
    // effective frequency per band, kHz: 225 .. 1500
    localparam logic [10:0] FSW_EFF [FSW_BANDS] = '{
        11'h0e1, 11'h113, 11'h145, 11'h177, 11'h1c2, 11'h226,
        11'h28a, 11'h2ee, 11'h384, 11'h44c, 11'h514, 11'h5dc};
    // valid floor range, same as the ceiling command
    localparam logic [15:0] FLOOR_MIN = 16'h0000;
    localparam logic [15:0] FLOOR_MAX = 16'hffff;

    // hardware divider factor
    typedef enum logic [1:0] {SF_EIGHTH, SF_QUARTER, SF_HALF, SF_ONE} lsvf_scale_e;

    // one host command
    typedef struct packed {
        logic [7:0] cmd;
        logic wrEn;
        logic rdEn;
        logic [15:0] data;
    } lsvf_req_s;

    // values held in nonvolatile storage
    typedef struct packed {
        logic [10:0] scaleMan;
        logic [15:0] floorWord;
        logic [10:0] freqKhz;
    } lsvf_nvm_s;

    // set pulses toward the status engine
    typedef struct packed {
        logic noneOfAbove;
        logic wordVout;
        logic floorCeilingWarning;
        logic invalidData;
    } lsvf_status_s;
endpackage : lsvf_pkg

// [verilog/lsvf_word_mem.sv]
// lsvf_word_mem: three command words with a registered read port.
// assumes one clock; reset loads the initial words synchronously.
`timescale 1ns/100ps
`default_nettype none
module lsvf_word_mem (
    input wire logic clock,
    input wire logic reset,
    input wire logic [47:0] initWords,
    input wire logic wrEn,
    input wire logic [1:0] wrIdx,
    input wire logic [15:0] wrData,
    input wire logic [1:0] rdIdx,
    output logic [15:0] rdData,
    output logic [47:0] words
);
    logic [15:0] mem [3]; // word storage

    // storage; words written here are kept unchanged
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gSlot
            always_ff @(posedge clock) begin
                if (reset) begin
                    mem[g] <= initWords[16*g +: 16];
                end else if (wrEn && wrIdx == 2'(g)) begin
                    mem[g] <= wrData;
                end
            end
            assign words[16*g +: 16] = mem[g];
        end
    endgenerate

    // read data leaves through a register
    always_ff @(posedge clock) begin
        if (reset) begin
            rdData <= 16'h0000;
        end else if (rdIdx == 2'h3) begin
            rdData <= 16'h0000;
        end else begin
            rdData <= mem[rdIdx];
        end
    end
endmodule : lsvf_word_mem
`default_nettype wire

// [verilog/lsvf_cmd_regs.sv]
// lsvf_cmd_regs: divider scale, output floor and switching frequency
// commands with quantization, floor clamping and invalid-data checks.
// assumes the host controller presents one decoded word command per
// cycle and that a status engine latches the set pulses.
// the ramp itself belongs to the slew generator outside.
//
// Contract
// R1 - scale word: exponent 15:11 resets 11001b
// R2 - in-range scale writes read back unchanged
// R3 - scale maps to 0.125, 0.25, 0.5, 1.0
// R4 - out-of-range writes flagged invalid, host notified
// R5 - reference scale uses written scale value
// R6 - frequency applies now only when conversion off
// R7 - floor at 2Bh, sixteen-bit unsigned word
// R8 - floor bounds commanded output always
// R9 - below-floor change warns, moves to floor
// R10 - floor violation sets three status bits
// R11 - ceiling above target gives same response
// R12 - floor range equals ceiling range
// R13 - frequency word layout, exponent made from storage
// R14 - frequency quantized onto twelve settings
// R15 - host avoids above 1100 kHz when stacked
// R16 - scale applies now only when conversion off
// R17 - clamp uses transition slew, not ramps
// R18 - decode mantissa times two to exponent
// R19 - gap values take lower band
`timescale 1ns/100ps
`default_nettype none
module lsvf_cmd_regs (
    input wire logic clock,
    input wire logic reset,
    input wire lsvf_pkg::lsvf_req_s req,
    input wire lsvf_pkg::lsvf_nvm_s nvm,
    input wire logic conversionOn,
    input wire logic restoreDone,
    input wire logic supplyCycled,
    input wire logic [15:0] targetReq,
    input wire logic targetChanged,
    input wire logic [15:0] outputVoltageCeiling,
    input wire logic ceilingWritten,
    output logic [15:0] rdData,
    output logic rdValid,
    output lsvf_pkg::lsvf_scale_e scaleFactor,
    output logic [16:0] refScale,
    output logic [3:0] freqCode,
    output logic [10:0] freqKhz,
    output logic [15:0] targetOut,
    output logic transSlewUsed,
    output lsvf_pkg::lsvf_status_s statusSet,
    output logic notifyHost
);
    import lsvf_pkg::*;

    // decode a signed linear word into fixed point with FRAC fraction bits
    function automatic logic signed [47:0] linToFix(input logic [15:0] w);
        logic signed [47:0] m;
        logic [4:0] sh;
        // sign-extend the eleven-bit mantissa
        m = {{37{w[MAN_HI]}}, w[MAN_HI:MAN_LO]};
        // exponent plus sixteen, always 0..31
        sh = {~w[EXP_HI], w[EXP_HI-1:EXP_LO]};
        // arithmetic shift keeps negative mantissas negative
        return m <<< sh; // R18
    endfunction : linToFix

    // map a decoded scale onto the hardware factor
    function automatic lsvf_scale_e scaleBand(input logic signed [47:0] f);
        if (f <= SCALE_LIM0) begin
            return SF_EIGHTH; // R3
        end else if (f <= SCALE_LIM1) begin
            // above an eighth, up to a quarter
            return SF_QUARTER;
        end else if (f <= SCALE_LIM2) begin
            // above a quarter, up to a half
            return SF_HALF;
        end else begin
            // anything above a half uses the full divider
            return SF_ONE;
        end
    endfunction : scaleBand

    // band index: count of band starts at or below the value
    function automatic logic [3:0] freqBand(input logic signed [47:0] f);
        logic [3:0] n;
        n = 4'h0;
        // starts ascend, so the last match wins
        for (int i = 0; i < FSW_BANDS - 1; i++) begin
            if (f >= ($signed({37'h0, FSW_START[i]}) <<< FRAC)) begin
                // value reaches this band start
                n = 4'(i + 1); // R19
            end
        end
        // values under the first start stay in band zero
        return n; // R14
    endfunction : freqBand

    // scale valid between zero (exclusive) and one
    function automatic logic scaleOk(input logic [15:0] w);
        logic signed [47:0] f;
        f = linToFix(w);
        // zero or negative would stall or invert the loop
        return (f > 48'sh0) && (f <= ONE_FIX);
    endfunction : scaleOk

    // frequency valid above zero and below the top band end
    function automatic logic freqOk(input logic [15:0] w);
        logic signed [47:0] f;
        f = linToFix(w);
        // the top band ends just short of the limit
        return (f > 48'sh0) && (f < ($signed({37'h0, FSW_LIMIT}) <<< FRAC));
    endfunction : freqOk

    // build the frequency word from a stored kHz value
    function automatic logic [15:0] freqWord(input logic [10:0] k);
        // mantissa is signed, so large values take exponent one
        if (k[10]) begin
            // the dropped low bit costs at most one kHz
            return {5'h01, 1'b0, k[10:1]}; // R13
        end else begin
            // small values fit the mantissa directly
            return {5'h00, k};
        end
    endfunction : freqWord

    logic [47:0] initWords; // reset contents of the word store
    logic [47:0] words; // current command words
    logic [15:0] scaleWord; // divider scale word
    logic [15:0] floorWord; // floor word
    logic [15:0] freqWordCur; // frequency word
    logic isScale; // command hits the scale word
    logic isFloor; // command hits the floor word
    logic isFreq; // command hits the frequency word
    logic wrValid; // in-range write
    logic wrBad; // out-of-range write
    logic [1:0] wrIdx; // store slot of this command
    logic applyAll_reg; // first cycle after reset
    logic applyAll_next;
    logic reload; // reset apply, restore or supply cycle seen
    logic scaleNow; // scale reaches hardware this cycle
    logic freqNow; // frequency reaches hardware this cycle
    logic [15:0] scaleSrc; // scale word being applied
    logic [15:0] freqSrc; // frequency word being applied
    logic signed [47:0] scaleFix; // decoded scale
    logic signed [47:0] freqFix; // decoded frequency
    logic [3:0] band; // frequency band index
    logic belowFloor; // requested target under floor
    logic floorEvent; // floor violation this cycle
    logic [15:0] targetNext; // bounded output target

    // reset image: scale exponent fixed, mantissa from storage
    assign initWords[16*IDX_SCALE +: 16] = {SCALE_EXP_RST, nvm.scaleMan}; // R1
    assign initWords[16*IDX_FLOOR +: 16] = nvm.floorWord;
    assign initWords[16*IDX_FREQ +: 16] = freqWord(nvm.freqKhz); // R13
    // the three slots fill all 48 bits of the image

    assign scaleWord = words[16*IDX_SCALE +: 16];
    assign floorWord = words[16*IDX_FLOOR +: 16];
    assign freqWordCur = words[16*IDX_FREQ +: 16];

    // command decode
    assign isScale = req.cmd == CMD_SCALE;
    assign isFloor = req.cmd == CMD_FLOOR; // R7
    assign isFreq = req.cmd == CMD_FREQ;
    assign wrIdx = isScale ? IDX_SCALE : (isFloor ? IDX_FLOOR : (isFreq ? IDX_FREQ : 2'h3));
    // slot three is unused and reads back as zero

    // range check per command; floor uses the ceiling range
    always_comb begin
        wrValid = 1'b0;
        if (isScale) begin
            // positive and at most one
            wrValid = scaleOk(req.data); // R4
        end else if (isFloor) begin
            // same limits as the ceiling word
            wrValid = (req.data >= FLOOR_MIN) && (req.data <= FLOOR_MAX); // R12
        end else if (isFreq) begin
            // positive and under the top band end
            wrValid = freqOk(req.data); // R4
        end
    end
    // writes to other codes belong to neighbouring blocks, not flagged here
    assign wrBad = req.wrEn && (isScale || isFloor || isFreq) && !wrValid;

    // word store; rejected writes leave the old value in place
    // reads come back one cycle late through the store's register
    lsvf_word_mem uMem (
        .clock(clock),
        .reset(reset),
        .initWords(initWords),
        .wrEn(req.wrEn && wrValid), // R2
        .wrIdx(wrIdx),
        .wrData(req.data),
        .rdIdx(wrIdx),
        .rdData(rdData),
        .words(words)
    );

    // read answer strobe, aligned with the registered read data
    always_ff @(posedge clock) begin
        if (reset) begin
            // no answer pending out of reset
            rdValid <= 1'b0;
        end else begin
            // only the three codes of this block answer
            rdValid <= req.rdEn && (isScale || isFloor || isFreq);
        end
    end

    // one-cycle flag that pushes the reset image into the hardware
    assign applyAll_next = 1'b0;
    always_ff @(posedge clock) begin
        if (reset) begin
            // held high for as long as reset lasts
            applyAll_reg <= 1'b1;
        end else begin
            // drops after the first edge out of reset
            applyAll_reg <= applyAll_next;
        end
    end

    // while converting, a written value waits for a reload;
    // the store keeps it, so the reload simply reads the store back
    assign reload = applyAll_reg || restoreDone || supplyCycled; // R6
    assign scaleNow = req.wrEn && isScale && wrValid && !conversionOn; // R16
    assign freqNow = req.wrEn && isFreq && wrValid && !conversionOn; // R6
    // a direct write bypasses the store for this cycle only
    assign scaleSrc = scaleNow ? req.data : scaleWord;
    assign freqSrc = freqNow ? req.data : freqWordCur;
    // decoded once; band and raw value both use it
    assign scaleFix = linToFix(scaleSrc);
    assign freqFix = linToFix(freqSrc);
    assign band = freqBand(freqFix);

    // divider hardware; reference scale follows the raw value, so an
    // unsupported scale can leave the output off its target
    always_ff @(posedge clock) begin
        if (reset) begin
            // full divider until the store is applied
            scaleFactor <= SF_ONE;
            refScale <= 17'h10000;
        end else if (scaleNow || reload) begin
            // factor is quantized, reference scale is not
            scaleFactor <= scaleBand(scaleFix); // R16
            refScale <= scaleFix[16:0]; // R5
        end
    end

    // oscillator setting
    always_ff @(posedge clock) begin
        if (reset) begin
            // lowest setting until the store is applied
            freqCode <= 4'h0;
            freqKhz <= FSW_EFF[0];
        end else if (freqNow || reload) begin
            // effective frequency follows the band index
            freqCode <= band; // R6
            freqKhz <= FSW_EFF[band]; // R14
        end
    end

    // floor bound on the commanded output
    // unsigned compare; both words share the output format
    assign belowFloor = targetReq < floorWord;
    assign targetNext = belowFloor ? floorWord : targetReq; // R8
    // only changes during conversion raise the warning
    // the ceiling case is kept exactly as the device behaves
    assign floorEvent = conversionOn && ((targetChanged && belowFloor)
        || (ceilingWritten && outputVoltageCeiling > targetOut)); // R11

    // bounded target and ramp selection toward the slew generator
    always_ff @(posedge clock) begin
        if (reset) begin
            // the slew generator starts from zero
            targetOut <= 16'h0000;
            transSlewUsed <= 1'b0;
        end else begin
            // the bound holds every cycle, converting or not
            targetOut <= targetNext; // R9
            // clamp moves while converting run at the transition rate, never a turn-on ramp
            transSlewUsed <= conversionOn && belowFloor; // R17
        end
    end

    // status set pulses and host notification
    always_ff @(posedge clock) begin
        if (reset) begin
            // no pulses pending out of reset
            statusSet <= '0;
            notifyHost <= 1'b0;
        end else begin
            // one-cycle pulses; the status engine latches them
            statusSet.noneOfAbove <= floorEvent; // R10
            statusSet.wordVout <= floorEvent; // R10
            statusSet.floorCeilingWarning <= floorEvent; // R9
            statusSet.invalidData <= wrBad; // R4
            // one notification covers both causes
            notifyHost <= floorEvent || wrBad; // R10
        end
    end
endmodule : lsvf_cmd_regs
`default_nettype wire

// [verification/lsvf_host_model.sv]
// lsvf_host_model: host controller side of the word command port.
// assumes the bench calls send and rd; each request lasts one cycle.
`timescale 1ns/100ps
`default_nettype none
module lsvf_host_model (
    input wire logic clock,
    input wire logic rdValid,
    input wire logic [15:0] rdData,
    output var lsvf_pkg::lsvf_req_s req
);
    import lsvf_pkg::*;
    // idle port at time zero
    initial req = '{8'h00, 1'b0, 1'b0, 16'h0000};
    // whole words only, never read and write together; a released word is
    // inverted so stale data never looks current
    // single-phase host: settings above 1100 kHz stay legal here
    task automatic send(input logic [7:0] c, input logic wr, input logic [15:0] d);
        @(negedge clock);
        req = '{c, wr, !wr, d};
        @(negedge clock);
        req = '{~c, 1'b0, 1'b0, ~d};
    endtask : send
    // bounded wait for the answer; ok stays low when none comes
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
        send(c, 1'b0, 16'h0000);
        ok = 1'b0;
        d = 16'h0000;
        // the answer stands in the cycle right after the request edge
        repeat (3) begin
            if (!ok && rdValid === 1'b1) begin
                ok = 1'b1;
                d = rdData;
            end
            @(negedge clock);
        end
    endtask : rd
endmodule : lsvf_host_model
`default_nettype wire

// [verification/lsvf_cmd_regs_sva.sv]
// lsvf_cmd_regs_sva: cycle checks on the command words and floor logic.
// assumes it is bound into lsvf_cmd_regs and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module lsvf_cmd_regs_sva (
    input wire logic clock,
    input wire logic reset,
    input wire lsvf_pkg::lsvf_req_s req,
    input wire logic conversionOn,
    input wire logic restoreDone,
    input wire logic supplyCycled,
    input wire logic [15:0] targetReq,
    input wire logic targetChanged,
    input wire logic [15:0] outputVoltageCeiling,
    input wire logic ceilingWritten,
    input wire logic rdValid,
    input wire lsvf_pkg::lsvf_scale_e scaleFactor,
    input wire logic [3:0] freqCode,
    input wire logic [15:0] targetOut,
    input wire logic transSlewUsed,
    input wire lsvf_pkg::lsvf_status_s statusSet,
    input wire logic notifyHost
);
    import lsvf_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic rdHit; // read of one of the three codes
    logic calm; // converting with no apply event pending
    assign rdHit = req.rdEn && (req.cmd == CMD_SCALE || req.cmd == CMD_FLOOR || req.cmd == CMD_FREQ);
    assign calm = conversionOn && !restoreDone && !supplyCycled && !reset;
    read_answer_a: assert property (rdHit |=> rdValid)
        else $error("mapped read not answered");
    read_only_a: assert property (!rdHit |=> !rdValid)
        else $error("answer without a mapped read");
    floor_bound_a: assert property (!reset |=> targetOut >= $past(targetReq))
        else $error("target below requested value");
    // while converting, the clamp and the slew flag must agree cycle for cycle
    slew_clamp_a: assert property (conversionOn |=> transSlewUsed == (targetOut != $past(targetReq)))
        else $error("slew flag and clamp disagree");
    warn_on_drop_a: assert property (conversionOn && targetChanged && !ceilingWritten
        |=> statusSet.floorCeilingWarning == transSlewUsed) else $error("floor warning mismatch");
    ceiling_warn_a: assert property (conversionOn && ceilingWritten
        && outputVoltageCeiling > targetOut |=> statusSet.floorCeilingWarning) else $error("no warning");
    warn_bundle_a: assert property (statusSet.floorCeilingWarning
        |-> statusSet.noneOfAbove && statusSet.wordVout && notifyHost) else $error("status set incomplete");
    // three quiet cycles rule out late applies of an earlier write
    hold_while_on_a: assert property (calm && $past(calm) && $past(calm, 2)
        |=> $stable(freqCode) && $stable(scaleFactor)) else $error("hardware updated while converting");
    cover property (statusSet.floorCeilingWarning);
    cover property (statusSet.invalidData);
    cover property (rdValid ##1 rdHit);
endmodule : lsvf_cmd_regs_sva
bind lsvf_cmd_regs lsvf_cmd_regs_sva u_sva (.clock, .reset, .req, .conversionOn, .restoreDone,
    .supplyCycled, .targetReq, .targetChanged, .outputVoltageCeiling, .ceilingWritten, .rdValid,
    .scaleFactor, .freqCode, .targetOut, .transSlewUsed, .statusSet, .notifyHost);
`default_nettype wire

// [verification/lsvf_cmd_regs_tb.sv]
// lsvf_cmd_regs_tb: self-checking bench for the three command words.
// assumes the host model drives the command port; inputs move on falling edges.
`timescale 1ns/100ps
`default_nettype none
module lsvf_cmd_regs_tb;
    import lsvf_pkg::*;
    logic clock = 1'b0, reset = 1'b1, conversionOn = 1'b0, restoreDone = 1'b0, ok;
    logic supplyCycled = 1'b0, targetChanged = 1'b0, ceilingWritten = 1'b0;
    logic rdValid, transSlewUsed, notifyHost;
    logic [15:0] targetReq = 16'h0000, outputVoltageCeiling = 16'h0000, rdData, targetOut, w, sw, got;
    logic [16:0] refScale;
    logic [3:0] freqCode;
    logic [10:0] freqKhz;
    lsvf_req_s req;
    lsvf_scale_e scaleFactor;
    lsvf_status_s statusSet;
    lsvf_nvm_s nvm = '{11'h040, 16'h0100, 11'h1f4}; // scale 0.5, floor 100h, 500 kHz
    int fail_count = 0, num_checks = 0, seed = 32'hac242c0e, nWarn = 0, nInv = 0, nNot = 0;
    int k, w0, n0, ew;
    int st[11] = '{251, 301, 351, 411, 501, 601, 701, 821, 1001, 1201, 1401};
    int eff[12] = '{225, 275, 325, 375, 450, 550, 650, 750, 900, 1100, 1300, 1500};
    int ms[8] = '{1, 16, 17, 32, 33, 64, 65, 128}; // band edges at exponent -7
    int fx[5] = '{250, 251, 1400, 1401, 1649}; // frequency band edges
    logic [23:0] bad[5] = '{24'h29c800, 24'h29cfff, 24'h29c881, 24'h330000, 24'h330b39};
    lsvf_cmd_regs DUT (.clock, .reset, .req, .nvm, .conversionOn, .restoreDone, .supplyCycled,
        .targetReq, .targetChanged, .outputVoltageCeiling, .ceilingWritten, .rdData, .rdValid,
        .scaleFactor, .refScale, .freqCode, .freqKhz, .targetOut, .transSlewUsed, .statusSet,
        .notifyHost);
    lsvf_host_model host (.clock, .rdValid, .rdData, .req);
    always #2 clock = ~clock;
    // count status pulses; their exact cycle is left to the checker
    always @(posedge clock) begin
        nWarn += statusSet.floorCeilingWarning & statusSet.noneOfAbove & statusSet.wordVout;
        nInv += statusSet.invalidData;
        nNot += notifyHost;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: saw %0h want %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask : step
    task automatic pulse(ref logic s);
        step(1);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask : pulse
    // a missing answer ends the run at once
    task automatic rdck(input logic [7:0] c, input logic [15:0] exp, input string what);
        host.rd(c, got, ok);
        check(ok, 1'b1, what);
        if (!ok) wrap_up();
        check(got, exp, what);
    endtask : rdck
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    function automatic int band(input int f);
        band = 0;
        foreach (st[i]) if (f >= st[i]) band = i + 1; // gaps fall to the lower band
    endfunction : band
    // 1.16 value of a positive word; only exponents up to zero are used here
    function automatic logic [16:0] dec(input logic [15:0] v);
        return 17'((longint'(v[10:0]) << 16) >> (5'd0 - v[15:11]));
    endfunction : dec
    function automatic lsvf_scale_e fac(input logic [16:0] r);
        return r <= 17'h02000 ? SF_EIGHTH : r <= 17'h04000 ? SF_QUARTER :
            r <= 17'h08000 ? SF_HALF : SF_ONE;
    endfunction : fac
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end
    initial begin
        step(6);
        reset = 1'b0;
        step(1);
        rdck(CMD_SCALE, {5'h19, nvm.scaleMan}, "scale reset");
        rdck(CMD_FLOOR, nvm.floorWord, "floor reset");
        rdck(CMD_FREQ, 16'h01f4, "freq reset");
        check(freqKhz, 11'd450, "freq applied");
        check(scaleFactor, SF_HALF, "scale applied");
        $display("test reset done");
        for (int i = 0; i < 18; i++) begin
            w = i < 5 ? {5'(i - 4), 11'd1} :
                {5'h19, 11'(i < 13 ? ms[i - 5] : 1 + $unsigned($random(seed)) % 128)};
            host.send(CMD_SCALE, 1'b1, w);
            step(1);
            rdck(CMD_SCALE, w, "scale readback");
            check(refScale, dec(w), "scale value");
            check(scaleFactor, fac(dec(w)), "scale factor");
        end
        sw = w;
        for (int i = 0; i < 16; i++) begin
            k = i < 5 ? fx[i] : 1 + $unsigned($random(seed)) % 1649;
            w = k < 1024 ? {5'h00, k[10:0]} : {5'h01, k[11:1]};
            host.send(CMD_FREQ, 1'b1, w);
            step(1);
            rdck(CMD_FREQ, w, "freq readback");
            k = band(k < 1024 ? k : k & ~1);
            check(freqCode, k, "freq band");
            check(freqKhz, eff[k], "freq value");
        end
        $display("test quantize done");
        foreach (bad[i]) begin
            w0 = nInv;
            host.send(bad[i][23:16], 1'b1, bad[i][15:0]);
            step(2);
            check(nInv - w0, 1, "invalid flag");
        end
        rdck(CMD_SCALE, sw, "scale kept");
        rdck(CMD_FREQ, w, "freq kept");
        $display("test invalid done");
        conversionOn = 1'b1;
        host.send(CMD_FREQ, 1'b1, 16'h012c);
        host.send(CMD_SCALE, 1'b1, 16'hc810);
        step(3);
        check(freqKhz, eff[k], "freq held");
        check(scaleFactor, fac(dec(sw)), "scale held");
        pulse(restoreDone);
        step(1);
        check(freqKhz, 11'd275, "freq restored");
        check(scaleFactor, SF_EIGHTH, "scale restored");
        host.send(CMD_FREQ, 1'b1, 16'h0abd);
        pulse(supplyCycled);
        step(1);
        check(freqKhz, 11'd1500, "freq after supply cycle");
        $display("test apply done");
        host.send(CMD_FLOOR, 1'b1, 16'h0200);
        w0 = nWarn;
        n0 = nNot;
        ew = 0;
        for (int i = 0; i < 10; i++) begin
            k = i == 0 ? 256 : $unsigned($random(seed)) % 1024;
            targetReq = k[15:0];
            ew += k < 512;
            pulse(targetChanged);
            step(1);
            check(targetOut, k < 512 ? 512 : k, "floor clamp");
            check(transSlewUsed, k < 512, "slew used");
            check(nWarn - w0, ew, "floor warning");
        end
        outputVoltageCeiling = 16'hffff;
        pulse(ceilingWritten);
        step(1);
        check(nWarn - w0, ew + 1, "ceiling warning");
        check(nNot - n0, ew + 1, "host notified");
        conversionOn = 1'b0;
        targetReq = 16'h0010;
        pulse(targetChanged);
        step(1);
        check(targetOut, 16'h0200, "floor while off");
        check(nWarn - w0, ew + 1, "no warning while off");
        w0 = nInv;
        host.send(CMD_FLOOR, 1'b1, 16'hffff);
        step(2);
        rdck(CMD_FLOOR, 16'hffff, "floor top");
        check(nInv - w0, 0, "floor top valid");
        check(targetOut, 16'hffff, "floor top bound");
        host.rd(8'h30, got, ok);
        check(ok, 1'b0, "unmapped code ignored");
        $display("test floor done");
        wrap_up();
    end
endmodule : lsvf_cmd_regs_tb
`default_nettype wire
